// *** verilog/dpsf_host_regs.svh ***
// timing counts and fixed values for the semaphore port controller
// assumes a 40 MHz ref_clk_i and a device pin set sampled on that clock
//
// Contract
// - flag access drives memory enable high and flag select low
// - at power-up software writes one into every flag from both ports
// - acquire is write zero then read back; only zero read means granted
// - a failed request keeps polling or withdraws by writing one
// - holder releases by writing one to the same flag when done
`ifndef DPSF_HOST_REGS_SVH
`define DPSF_HOST_REGS_SVH

// ==========================================================
// clock and strobe timing
`define DPSF_CLK_NS      25
`define DPSF_WR_NS       50
`define DPSF_HOLD_NS     25
`define DPSF_RD_NS       50
`define DPSF_GAP_NS      25
`define DPSF_WR_CYC      3'((`DPSF_WR_NS + `DPSF_CLK_NS - 1) / `DPSF_CLK_NS)
`define DPSF_HOLD_CYC    3'((`DPSF_HOLD_NS + `DPSF_CLK_NS - 1) / `DPSF_CLK_NS)
`define DPSF_RD_CYC      3'((`DPSF_RD_NS + `DPSF_CLK_NS - 1) / `DPSF_CLK_NS)
`define DPSF_GAP_CYC     3'((`DPSF_GAP_NS + `DPSF_CLK_NS - 1) / `DPSF_CLK_NS)

// ==========================================================
// flag space
`define DPSF_LAST_IDX    3'h7
`define DPSF_POLL_MAX    5'h10

`endif

// *** verilog/dpsf_host_pkg.sv ***
// types for the semaphore port controller
// assumes dpsf_host_regs.svh supplies the numbers
package dpsf_host_pkg;

    // ==========================================================
    // controller states
    typedef enum logic [2:0] {
        DPSF_IDLE = 3'h0,
        DPSF_WR   = 3'h1,
        DPSF_WEND = 3'h2,
        DPSF_RD   = 3'h3,
        DPSF_GAP  = 3'h4,
        DPSF_DONE = 3'h5
    } dpsf_state_e;

    // ==========================================================
    // commands
    typedef enum logic [1:0] {
        DPSF_OP_INIT = 2'h0,
        DPSF_OP_ACQ  = 2'h1,
        DPSF_OP_REL  = 2'h2,
        DPSF_OP_BAD  = 2'h3
    } dpsf_op_e;

    // ==========================================================
    // whole module state
    typedef struct packed {
        dpsf_state_e st;
        logic [2:0]  cnt;
        logic [2:0]  idx;
        dpsf_op_e    op;
        logic        poll;
        logic [4:0]  tries;
        logic        wval;
        logic        last_rd;
        logic        flag;
        logic        ce_n;
        logic        sel_n;
        logic        rw_n;
        logic        oe_n;
        logic [2:0]  addr;
        logic [7:0]  dout;
        logic        doe_n;
        logic        ready;
        logic        done;
        logic        granted;
        logic        failed;
    } dpsf_state_s;

endpackage

// *** verilog/dpsf_host.sv ***
// controller for one port of the shared semaphore flags
// assumes the device pins are sampled synchronously to ref_clk_i
// assumes the far side commits a flag write on the rising write strobe
`timescale 1ns/1ps
`include "dpsf_host_regs.svh"

module dpsf_host (
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       arst_n_i,
    // command side
    input  wire logic       cmd_valid_i,
    input  wire logic [1:0] cmd_op_i,
    input  wire logic [2:0] cmd_idx_i,
    input  wire logic       cmd_poll_i,
    output logic            cmd_ready_o,
    output logic            done_o,
    output logic            granted_o,
    output logic            failed_o,
    // device pins
    output logic            ce_n_o,
    output logic            flag_select_n_o,
    output logic            rw_n_o,
    output logic            oe_n_o,
    output logic [2:0]      flag_index_o,
    output logic [7:0]      data_o,
    output logic            data_oe_n_o,
    input  wire logic [7:0] data_i
);

    // ==========================================================
    // state storage
    // r is the registered copy, n the value it takes at the next edge;
    // every pin leaves r, so no output shows a combinational glitch
    dpsf_host_pkg::dpsf_state_s r;
    dpsf_host_pkg::dpsf_state_s n;

    // ==========================================================
    // next state
    // one access is write strobe, write hold and gap; an acquire adds a
    // read strobe and a second gap, and the gaps drop select and output
    // enable so the far side relatches the flag on every read
    // limitation: one command at a time, a new one waits for cmd_ready_o
    always_comb begin
        // hold everything unless a branch says otherwise; done is a pulse
        n      = r;
        n.done = 1'b0;

        // one branch per controller state
        unique case (r.st)
            // idle: wait for a command, last result stays visible
            dpsf_host_pkg::DPSF_IDLE: begin
                if (cmd_valid_i && r.ready) begin
                    // take the command and clear the previous result
                    n.ready   = 1'b0;
                    n.op      = dpsf_host_pkg::dpsf_op_e'(cmd_op_i);
                    n.poll    = cmd_poll_i;
                    n.tries   = 5'h00;
                    n.granted = 1'b0;
                    n.failed  = 1'b0;
                    n.cnt     = `DPSF_WR_CYC - 3'h1;
                    n.st      = dpsf_host_pkg::DPSF_WR;
                    // init walks every flag from index zero
                    n.idx  = (n.op == dpsf_host_pkg::DPSF_OP_INIT) ? 3'h0 : cmd_idx_i;
                    // acquire writes zero, init and release write one
                    n.wval = (n.op == dpsf_host_pkg::DPSF_OP_ACQ) ? 1'b0 : 1'b1;
                    // unknown op: report failure at once, no strobe moves
                    if (n.op == dpsf_host_pkg::DPSF_OP_BAD) begin
                        n.failed = 1'b1;
                        n.st     = dpsf_host_pkg::DPSF_DONE;
                    end
                end
            end

            // write strobe: select and write enable low, data driven
            dpsf_host_pkg::DPSF_WR: begin
                if (r.cnt != 3'h0) begin
                    n.cnt = r.cnt - 3'h1;
                end else begin
                    // rising write strobe commits bit zero
                    n.cnt = `DPSF_HOLD_CYC - 3'h1;
                    n.st  = dpsf_host_pkg::DPSF_WEND;
                end
            end

            // write hold: strobe back high, select and data kept one cycle more
            dpsf_host_pkg::DPSF_WEND: begin
                if (r.cnt != 3'h0) begin
                    n.cnt = r.cnt - 3'h1;
                end else begin
                    // the write has committed; what follows is a write gap
                    n.last_rd = 1'b0;
                    n.cnt     = `DPSF_GAP_CYC - 3'h1;
                    n.st      = dpsf_host_pkg::DPSF_GAP;
                end
            end

            // read strobe: the far side latches the flag as the strobes fall
            // hazard: a peer write during the strobe shows only on the next read
            dpsf_host_pkg::DPSF_RD: begin
                if (r.cnt != 3'h0) begin
                    n.cnt = r.cnt - 3'h1;
                end else begin
                    // sample on the last cycle, before the strobes release
                    n.flag    = data_i[0]; // value is spread, bit zero suffices
                    n.last_rd = 1'b1;
                    n.cnt     = `DPSF_GAP_CYC - 3'h1;
                    n.st      = dpsf_host_pkg::DPSF_GAP;
                end
            end

            // gap: all strobes idle, then pick the next step
            dpsf_host_pkg::DPSF_GAP: begin
                // strobes idle here so the next read relatches
                if (r.cnt != 3'h0) begin
                    n.cnt = r.cnt - 3'h1;
                end else begin
                    // next step depends on the command in flight
                    unique case (r.op)
                        dpsf_host_pkg::DPSF_OP_INIT: begin
                            // all eight flags written once from this side
                            if (r.idx == `DPSF_LAST_IDX) begin
                                n.st = dpsf_host_pkg::DPSF_DONE;
                            end else begin
                                n.idx = r.idx + 3'h1;
                                n.cnt = `DPSF_WR_CYC - 3'h1;
                                n.st  = dpsf_host_pkg::DPSF_WR;
                            end
                        end
                        dpsf_host_pkg::DPSF_OP_ACQ: begin
                            // last_rd tells a finished write from a finished read
                            if (!r.last_rd && !r.wval) begin
                                // request written, now verify it
                                n.cnt = `DPSF_RD_CYC - 3'h1;
                                n.st  = dpsf_host_pkg::DPSF_RD;
                            end else if (!r.last_rd) begin
                                // withdrawal written, report failure
                                n.failed = 1'b1;
                                n.st     = dpsf_host_pkg::DPSF_DONE;
                            end else if (!r.flag) begin
                                n.granted = 1'b1; // only a zero means owned
                                n.st      = dpsf_host_pkg::DPSF_DONE;
                            end else if (r.poll && r.tries != `DPSF_POLL_MAX) begin
                                // bounded polling so a dead peer cannot hang us
                                n.tries = r.tries + 5'h01;
                                n.cnt   = `DPSF_RD_CYC - 3'h1;
                                n.st    = dpsf_host_pkg::DPSF_RD;
                            end else begin
                                // pending zero would block the flag forever
                                n.wval = 1'b1;
                                n.cnt  = `DPSF_WR_CYC - 3'h1;
                                n.st   = dpsf_host_pkg::DPSF_WR;
                            end
                        end
                        default: begin
                            n.st = dpsf_host_pkg::DPSF_DONE; // release finished
                        end
                    endcase
                end
            end

            // one-cycle done pulse, ready returns with it
            dpsf_host_pkg::DPSF_DONE: begin
                n.done  = 1'b1;
                n.ready = 1'b1;
                n.st    = dpsf_host_pkg::DPSF_IDLE;
            end

            // unused state codes fall back to idle
            default: begin
                n.st    = dpsf_host_pkg::DPSF_IDLE;
                n.ready = 1'b1;
            end
        endcase

        // pins follow the next state so they leave a flip-flop
        n.ce_n  = 1'b1; // memory array never enabled here
        n.sel_n = !(n.st == dpsf_host_pkg::DPSF_WR || n.st == dpsf_host_pkg::DPSF_WEND ||
                    n.st == dpsf_host_pkg::DPSF_RD);
        // write strobe low only in the strobe phase; its rising edge commits
        n.rw_n  = !(n.st == dpsf_host_pkg::DPSF_WR);
        // output enable only in the read phase, released in every gap
        n.oe_n  = !(n.st == dpsf_host_pkg::DPSF_RD);
        // data stays driven through the hold so bit zero is stable at commit
        n.doe_n = !(n.st == dpsf_host_pkg::DPSF_WR || n.st == dpsf_host_pkg::DPSF_WEND);

        // flag index and bit zero; upper data bits are always zero
        n.addr  = n.idx;
        n.dout  = {7'h00, n.wval};
    end

    // ==========================================================
    // state register
    // reset parks every strobe inactive, so a floating select cannot
    // turn a reset into a spurious flag write
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '{st: dpsf_host_pkg::DPSF_IDLE, op: dpsf_host_pkg::DPSF_OP_INIT,
                   wval: 1'b1, flag: 1'b1, ce_n: 1'b1, sel_n: 1'b1, rw_n: 1'b1,
                   oe_n: 1'b1, doe_n: 1'b1, ready: 1'b1, default: '0};
        end else begin
            r <= n;
        end
    end

    // ==========================================================
    // outputs
    // command side
    assign cmd_ready_o     = r.ready;
    assign done_o          = r.done;
    assign granted_o       = r.granted;
    assign failed_o        = r.failed;

    // device pins, straight from the state register
    assign ce_n_o          = r.ce_n;
    assign flag_select_n_o = r.sel_n;
    assign rw_n_o          = r.rw_n;
    assign oe_n_o          = r.oe_n;
    assign flag_index_o    = r.addr;
    assign data_o          = r.dout;
    assign data_oe_n_o     = r.doe_n;

endmodule // dpsf_host

// *** verif/dpsf_host_props.sv ***
// pin checks for one semaphore port controller
// assumes binding onto dpsf_host, one clock domain
`timescale 1ns/1ps
module dpsf_host_props (
    // clock, reset, command side
    input wire logic       ref_clk_i,
    input wire logic       arst_n_i,
    input wire logic       cmd_valid_i,
    input wire logic [1:0] cmd_op_i,
    input wire logic [2:0] cmd_idx_i,
    input wire logic       cmd_ready_o,
    input wire logic       done_o,
    input wire logic       granted_o,
    input wire logic       failed_o,
    // device pins
    input wire logic       ce_n_o,
    input wire logic       flag_select_n_o,
    input wire logic       rw_n_o,
    input wire logic       oe_n_o,
    input wire logic [2:0] flag_index_o,
    input wire logic [7:0] data_o,
    input wire logic       data_oe_n_o,
    input wire logic [7:0] data_i
);
    // ==========================================================
    // helper state: command taken, last strobe values
    logic [2:0] idx_r;
    logic [1:0] op_r;
    logic       rd_r;
    logic       wr_r;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            idx_r <= 3'h0;
            op_r  <= 2'h0;
            rd_r  <= 1'b1;
            wr_r  <= 1'b1;
        end else begin
            if (cmd_valid_i && cmd_ready_o) begin
                idx_r <= cmd_idx_i;
                op_r  <= cmd_op_i;
            end
            if (!oe_n_o) rd_r <= data_i[0];
            if (!rw_n_o) wr_r <= data_o[0];
        end
    end
    // ==========================================================
    // steps of a flag access
    sequence s_take(logic [1:0] op);
        cmd_valid_i && cmd_ready_o && cmd_op_i == op;
    endsequence
    sequence s_wr(logic v);
        !rw_n_o && !flag_select_n_o && data_o[0] == v && flag_index_o == idx_r;
    endsequence
    mem_off_a: assert property (ce_n_o)
        else $error("memory enable active");
    wr_select_a: assert property (!rw_n_o |-> !flag_select_n_o && !data_oe_n_o)
        else $error("write strobe without flag select");
    rd_quiet_a: assert property (!oe_n_o |-> !flag_select_n_o && data_oe_n_o && rw_n_o)
        else $error("read phase malformed");
    wbit_only_a: assert property (!data_oe_n_o |-> data_o[7:1] == 7'h0)
        else $error("upper data bits driven");
    acq_write_a: assert property (s_take(2'h1) |-> ##[1:2] s_wr(1'b0) ##[1:6] !oe_n_o)
        else $error("acquire not write zero then read");
    acq_grant_a: assert property (done_o && granted_o |-> !rd_r && !wr_r)
        else $error("grant without zero readback");
    fail_withdraw_a: assert property (done_o && failed_o && op_r == 2'h1 |-> rd_r && wr_r)
        else $error("failed acquire not withdrawn");
    rel_write_a: assert property (s_take(2'h2) |-> ##[1:2] s_wr(1'b1) ##[2:6] done_o)
        else $error("release did not write one");
    init_ones_a: assert property (!rw_n_o && op_r == 2'h0 |-> data_o[0])
        else $error("init wrote zero");
    init_done_a: assert property (s_take(2'h0) |-> ##[30:38] done_o)
        else $error("init did not finish");
endmodule // dpsf_host_props

bind dpsf_host dpsf_host_props u_props (
    .ref_clk_i, .arst_n_i, .cmd_valid_i, .cmd_op_i, .cmd_idx_i, .cmd_ready_o,
    .done_o, .granted_o, .failed_o, .ce_n_o, .flag_select_n_o, .rw_n_o,
    .oe_n_o, .flag_index_o, .data_o, .data_oe_n_o, .data_i
);

// *** verif/dpsf_sem_model.sv ***
// behavioural model of the eight shared flags, two ports
// assumes port 0 faces the controller, port 1 the bench
`timescale 1ns/1ps
module dpsf_sem_model (
    // port pins, bit p belongs to port p, idx_i bits 3p to 3p+2
    input  wire logic [1:0] ce_n_i,
    input  wire logic [1:0] sel_n_i,
    input  wire logic [1:0] rw_n_i,
    input  wire logic [1:0] oe_n_i,
    input  wire logic [5:0] idx_i,
    input  wire logic [1:0] wbit_i,
    // read data per port
    output logic [7:0]      rd0_o,
    output logic [7:0]      rd1_o
);
    // ==========================================================
    // owner per flag: 0 free, 1 port 0, 2 port 1
    logic [1:0] own [8];
    logic [1:0] req [8];
    logic [7:0] rd [2];
    logic [1:0] act;
    assign rd0_o = rd[0];
    assign rd1_o = rd[1];
    // power-up leaves requests pending, so init from both sides matters
    initial begin
        act = 2'h0;
        rd[0] = 8'h00;
        rd[1] = 8'h00;
        for (int i = 0; i < 8; i++) begin
            own[i] = 2'h2;
            req[i] = 2'h0;
        end
    end
    task automatic commit(input int p, input logic [2:0] i, input logic v);
        logic [1:0] me;
        me = 2'(p + 1);
        req[i][p] = v; // a losing zero only sits in its latch
        if (!v && own[i] == 2'h0) own[i] = me; // first writer wins alone
        else if (v && own[i] == me) own[i] = req[i][1-p] ? 2'h0 : 2'(2 - p);
    endtask
    // read value frozen while select and output enable stay active
    task automatic look(input int p);
        logic a;
        a = !sel_n_i[p] && !oe_n_i[p];
        if (a && !act[p]) rd[p] = {8{own[idx_i[3*p+:3]] != 2'(p + 1)}};
        else if (!a && act[p]) rd[p] = ~rd[p]; // released bus keeps no stale value
        act[p] = a;
    endtask
    always @(posedge rw_n_i[0]) if (!sel_n_i[0] && ce_n_i[0]) commit(0, idx_i[2:0], wbit_i[0]);
    always @(posedge rw_n_i[1]) if (!sel_n_i[1] && ce_n_i[1]) commit(1, idx_i[5:3], wbit_i[1]);
    always @(sel_n_i[0], oe_n_i[0]) look(0);
    always @(sel_n_i[1], oe_n_i[1]) look(1);
endmodule // dpsf_sem_model

// *** verif/tb.sv ***
// self-checking bench: controller on port 0, bench plays port 1
// assumes the flag model answers both ports
`timescale 1ns/1ps
module tb;
    // ==========================================================
    // stimulus and observed signals
    logic       ref_clk_i, arst_n_i, cmd_valid_i, cmd_poll_i, rv;
    logic [1:0] cmd_op_i;
    logic [2:0] cmd_idx_i, flag_index_o, b_idx;
    logic       cmd_ready_o, done_o, granted_o, failed_o, ce_n_o, rw_n_o, oe_n_o;
    logic       flag_select_n_o, data_oe_n_o, b_sel, b_rw, b_oe, b_w;
    logic [7:0] data_o, data_i, rd1;
    int         num_errors = 0;
    int         checks = 0;
    dpsf_host u_dpsf_host (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
        .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_idx_i(cmd_idx_i),
        .cmd_poll_i(cmd_poll_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
        .granted_o(granted_o), .failed_o(failed_o), .ce_n_o(ce_n_o),
        .flag_select_n_o(flag_select_n_o), .rw_n_o(rw_n_o), .oe_n_o(oe_n_o),
        .flag_index_o(flag_index_o), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
        .data_i(data_i));
    dpsf_sem_model u_dpsf_sem_model (.ce_n_i({1'b1, ce_n_o}),
        .sel_n_i({b_sel, flag_select_n_o}), .rw_n_i({b_rw, rw_n_o}),
        .oe_n_i({b_oe, oe_n_o}), .idx_i({b_idx, flag_index_o}),
        .wbit_i({b_w, data_o[0]}), .rd0_o(data_i), .rd1_o(rd1));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================================
    // one controller command, waits on done with a bound
    task automatic cmd(input logic [1:0] op, input logic [2:0] i, input logic poll);
        int n;
        @(posedge ref_clk_i);
        {cmd_valid_i, cmd_op_i, cmd_idx_i, cmd_poll_i} <= {1'b1, op, i, poll};
        @(posedge ref_clk_i);
        cmd_valid_i <= 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 200) @(negedge ref_clk_i) n++;
        if (n == 200) num_errors++;
    endtask
    // bench port access: write v, or read into rv
    task automatic acc1(input logic wr, input logic [2:0] i, input logic v);
        @(posedge ref_clk_i);
        {b_sel, b_idx, b_w, b_rw, b_oe} <= {1'b0, i, v, !wr, wr};
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i) rv = rd1[0];
        @(posedge ref_clk_i);
        {b_rw, b_oe} <= 2'h3; // rising strobe commits while select stays low
        @(posedge ref_clk_i);
        b_sel <= 1'b1;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_loop();
        for (int i = 0; i < 8; i++) begin
            cmd(2'h1, 3'(i), 1'b0);
            chk(granted_o, 1'b1);
            acc1(1'b0, 3'(i), 1'b1);
            chk(rv, 1'b1);
            cmd(2'h2, 3'(i), 1'b0);
            acc1(1'b1, 3'(i), 1'b0);
            acc1(1'b0, 3'(i), 1'b1);
            chk(rv, 1'b0);
            acc1(1'b1, 3'(i), 1'b1);
        end
    endtask
    task automatic t_contend();
        acc1(1'b1, 3'h5, 1'b0);
        cmd(2'h1, 3'h5, 1'b0);
        chk({granted_o, failed_o}, 2'h1);
        acc1(1'b1, 3'h5, 1'b1);
        acc1(1'b0, 3'h5, 1'b1);
        chk(rv, 1'b1); // withdrawn, nothing pending
        cmd(2'h1, 3'h3, 1'b0);
        acc1(1'b1, 3'h3, 1'b0);
        acc1(1'b0, 3'h3, 1'b1);
        chk(rv, 1'b1);
        cmd(2'h2, 3'h3, 1'b0);
        acc1(1'b0, 3'h3, 1'b1);
        chk(rv, 1'b0);
        acc1(1'b1, 3'h3, 1'b1);
    endtask
    task automatic t_poll_tie();
        acc1(1'b1, 3'h6, 1'b0);
        fork
            cmd(2'h1, 3'h6, 1'b1);
            begin repeat (20) @(posedge ref_clk_i); acc1(1'b1, 3'h6, 1'b1); end
        join
        chk(granted_o, 1'b1);
        cmd(2'h2, 3'h6, 1'b0);
        fork
            cmd(2'h1, 3'h2, 1'b0);
            acc1(1'b1, 3'h2, 1'b0); // same start edge: both writes commit together
        join
        acc1(1'b0, 3'h2, 1'b1);
        chk(granted_o, rv);
        cmd(2'h2, 3'h2, 1'b0);
        acc1(1'b1, 3'h2, 1'b1);
        cmd(2'h3, 3'h0, 1'b0);
        chk({granted_o, failed_o}, 2'h1);
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    // watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        num_errors++;
        report_and_stop();
    end
    initial begin
        {arst_n_i, cmd_valid_i, cmd_op_i, cmd_idx_i, cmd_poll_i} = 8'h00;
        {b_sel, b_rw, b_oe, b_idx, b_w} = 7'h71;
        repeat (10) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        @(negedge ref_clk_i);
        chk({cmd_ready_o, ce_n_o, flag_select_n_o, rw_n_o, oe_n_o, data_oe_n_o}, 8'h3f);
        cmd(2'h0, 3'h0, 1'b0);
        for (int i = 0; i < 8; i++) acc1(1'b1, 3'(i), 1'b1);
        t_loop();
        t_contend();
        t_poll_tie();
        report_and_stop();
    end
endmodule // tb
